// file: src/fault_status_pkg.sv
/*
  constants shared by the controller fault status bank: register offsets,
  field positions, masks, reset values and interrupt bit positions.
  assumes a byte-wide register address with registers at their own offsets.
*/
package fault_status_pkg;
  // register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register offsets
  localparam logic [ADDR_W-1:0] FAULT_FLAGS_OFF = 8'he2;
  localparam logic [ADDR_W-1:0] ALGO_STATE_OFF = 8'he4;
  localparam logic [ADDR_W-1:0] MOTOR_VALUES_OFF = 8'he6;
  localparam logic [ADDR_W-1:0] MEASURE_STATE_OFF = 8'he8;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFF = 8'hf0;
  localparam logic [ADDR_W-1:0] IRQ_CLEAR_OFF = 8'hf1;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFF = 8'hf2;
  localparam logic [ADDR_W-1:0] FAULT_CTRL_OFF = 8'hf3;

  // value of every register after reset
  localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;

  // fault flag bit positions
  localparam int SUMMARY_BIT = 31;
  localparam int OVERTEMP_BIT = 30;
  localparam int PROBE_FREQ_BIT = 29;
  localparam int PROBE_T1_BIT = 28;
  localparam int PROBE_T2_BIT = 27;
  localparam int BUS_LIMIT_BIT = 26;
  localparam int WINDING_BIT = 25;
  localparam int BACKEMF_MEAS_BIT = 24;
  localparam int RATE_LOCK_BIT = 23;
  localparam int BACKEMF_LOCK_BIT = 22;
  localparam int ABSENT_BIT = 21;
  localparam int ANY_LOCK_BIT = 20;
  localparam int LOCK_CURRENT_BIT = 19;
  localparam int HW_LOCK_BIT = 18;
  localparam int SUPPLY_LOW_BIT = 17;
  localparam int SUPPLY_HIGH_BIT = 16;
  localparam int SPEED_SAT_BIT = 15;
  localparam int CURRENT_SAT_BIT = 14;
  localparam int WATCHDOG_BIT = 3;
  localparam int SELFTEST_EN_BIT = 2;
  localparam int SELFTEST_RES_BIT = 1;
  localparam int APP_RESET_BIT = 0;

  // latched flags, flags feeding the summary, and live levels
  localparam logic [DATA_W-1:0] STICKY_MASK = 32'h7bff_0008;
  localparam logic [DATA_W-1:0] SUMMARY_MASK = 32'h7fff_c008;
  localparam logic [DATA_W-1:0] LIVE_MASK = 32'h0400_c007;

  // system status field positions and widths
  localparam int VOLT_MAG_LSB = 16;
  localparam int VOLT_MAG_W = 16;
  localparam int DUTY_LSB = 4;
  localparam int DUTY_W = 12;
  localparam int INIT_DONE_BIT = 3;
  localparam int SYS_ENABLE_BIT = 2;
  localparam int MOTOR_R_LSB = 24;
  localparam int BEMF_CONST_LSB = 16;
  localparam int MOTOR_L_LSB = 8;
  localparam int MOTOR_W = 8;
  localparam int MEAS_STAT_LSB = 28;
  localparam int MEAS_STAT_W = 4;
  localparam int PWM_FREQ_LSB = 24;
  localparam int PWM_FREQ_W = 4;

  // interrupt and control bits
  localparam int IRQ_W = 4;
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_WATCHDOG_BIT = 1;
  localparam int IRQ_INIT_BIT = 2;
  localparam int IRQ_MEAS_BIT = 3;
  localparam int FAULT_CLEAR_BIT = 0;
  localparam int PIN_SYNC_W = 3;
endpackage : fault_status_pkg

// file: src/bit_sync.sv
/*
  two-stage synchroniser, one chain per bit.
  assumes inputs are asynchronous levels; first stage feeds only the second.
*/
module bit_sync #(
  parameter int WIDTH = 3
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  // one two-flop chain per bit
  for (genvar g = 0; g < WIDTH; g++) begin : g_chain
    logic meta_q;
    logic stable_q;
    always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        meta_q <= 1'b0;
        stable_q <= 1'b0;
      end else if (ce_i) begin
        meta_q <= async_i[g];
        stable_q <= meta_q;
      end
    end
    assign sync_o[g] = stable_q;
  end
endmodule : bit_sync

// file: src/irq_bank.sv
/*
  sticky interrupt status with write-one-to-clear and an enable register.
  assumes events are single-clock pulses from the same clock domain.
*/
module irq_bank #(
  parameter int WIDTH = 4
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] event_i,
  input wire logic clear_we_i,
  input wire logic enable_we_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [WIDTH-1:0] status_o,
  output logic [WIDTH-1:0] enable_o,
  output logic irq_o
);
  logic [WIDTH-1:0] status_q;
  logic [WIDTH-1:0] enable_q;

  // sticky status, a new event wins over a clear in the same cycle
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status_q <= '0;
    end else if (ce_i) begin
      status_q <= (status_q & ~(clear_we_i ? wdata_i : '0)) | event_i;
    end
  end

  // interrupt enable register
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      enable_q <= '0;
    end else if (ce_i && enable_we_i) begin
      enable_q <= wdata_i;
    end
  end

  // level interrupt while an enabled bit is pending
  assign irq_o = |(status_q & enable_q);
  assign status_o = status_q;
  assign enable_o = enable_q;
endmodule : irq_bank

// file: src/controller_fault_status_bank.sv
/*
  controller fault status bank: the controller fault flags register, the
  three system status registers, interrupt status/clear/enable and a fault
  control register, all behind a simple address/strobe register port.
  assumes fault and status inputs come from logic on mclk_i, except the
  hardware lock current and supply comparator levels, which arrive from pins.
  // Overview of operation
  // (RL1) fault flags register at its own offset, read-only, zero after reset
  // (RL2) top bit is the OR of all individual controller fault flags
  // (RL3) bit 30 flags engine overtemperature
  // (RL4) bits 29..27 flag rotor probe frequency, first and second timing errors
  // (RL5) bit 26 shows whether the supply bus current limit is active now
  // (RL6) bit 25 winding measure error, bit 24 back-EMF measure error
  // (RL7) bits 23..21 rate lock, back-EMF lock, motor absent; bit 20 any lock
  // (RL8) bit 19 lock current error, bit 18 hardware lock current error
  // (RL9) bit 17 motor supply low, bit 16 motor supply high
  // (RL10) bit 15 speed loop saturation, bit 14 current loop saturation
  // (RL11) bit 3 flags a watchdog fault
  // (RL12) three system status registers at their offsets, reset to zero
  // (RL13) host never writes offsets that the map does not list
  // (RL14) bits 13..4 read zero; bits 2..0 self-test and application reset
*/
module controller_fault_status_bank (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // register port
  input wire logic [fault_status_pkg::ADDR_W-1:0] addr_i,
  input wire logic [fault_status_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [fault_status_pkg::DATA_W-1:0] rdata_o,
  output logic irq_o,
  // fault levels from the control engine
  input wire logic engine_overtemp_flag_i,
  input wire logic rotor_probe_freq_error_i,
  input wire logic rotor_probe_timing1_error_i,
  input wire logic rotor_probe_timing2_error_i,
  input wire logic bus_current_limit_active_i,
  input wire logic winding_measure_error_i,
  input wire logic backemf_measure_error_i,
  input wire logic abnormal_rate_lock_i,
  input wire logic abnormal_backemf_lock_i,
  input wire logic motor_absent_error_i,
  input wire logic lock_current_error_i,
  input wire logic speed_loop_saturated_i,
  input wire logic current_loop_saturated_i,
  input wire logic watchdog_error_i,
  input wire logic selftest_enabled_i,
  input wire logic selftest_result_i,
  input wire logic app_reset_seen_i,
  // comparator levels from pins
  input wire logic hardware_lock_current_error_i,
  input wire logic motor_supply_low_error_i,
  input wire logic motor_supply_high_error_i,
  // system status values
  input wire logic [fault_status_pkg::VOLT_MAG_W-1:0] volt_magnitude_i,
  input wire logic [fault_status_pkg::DUTY_W-1:0] duty_command_i,
  input wire logic init_done_i,
  input wire logic system_enabled_i,
  input wire logic [fault_status_pkg::MOTOR_W-1:0] winding_resistance_i,
  input wire logic [fault_status_pkg::MOTOR_W-1:0] backemf_constant_i,
  input wire logic [fault_status_pkg::MOTOR_W-1:0] winding_inductance_i,
  input wire logic [fault_status_pkg::MEAS_STAT_W-1:0] measure_status_i,
  input wire logic [fault_status_pkg::PWM_FREQ_W-1:0] measure_pwm_freq_i
);
  import fault_status_pkg::*;

  logic [PIN_SYNC_W-1:0] pin_async;
  logic [PIN_SYNC_W-1:0] pin_sync;
  logic hw_lock_s;
  logic supply_low_s;
  logic supply_high_s;
  logic any_lock;
  logic [DATA_W-1:0] fault_raw;
  logic [DATA_W-1:0] fault_d;
  logic [DATA_W-1:0] fault_q;
  logic fault_clear;
  logic [DATA_W-1:0] algo_d;
  logic [DATA_W-1:0] algo_q;
  logic [DATA_W-1:0] motor_d;
  logic [DATA_W-1:0] motor_q;
  logic [DATA_W-1:0] meas_d;
  logic [DATA_W-1:0] meas_q;
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic irq_clear_we;
  logic irq_enable_we;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;

  // comparator levels cross into the clock domain first
  assign pin_async = {hardware_lock_current_error_i, motor_supply_low_error_i, motor_supply_high_error_i};

  bit_sync #(
    .WIDTH(PIN_SYNC_W)
  ) u_pin_sync (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .async_i(pin_async),
    .sync_o(pin_sync)
  );

  assign hw_lock_s = pin_sync[2];
  assign supply_low_s = pin_sync[1];
  assign supply_high_s = pin_sync[0];

  // any of the five lock kinds raises the common lock flag
  assign any_lock = abnormal_rate_lock_i | abnormal_backemf_lock_i | motor_absent_error_i
                    | lock_current_error_i | hw_lock_s; // [RL7]

  // raw flag vector, reserved positions stay zero
  always_comb begin
    fault_raw = REG_RESET; // [RL14]
    fault_raw[OVERTEMP_BIT] = engine_overtemp_flag_i; // [RL3]
    fault_raw[PROBE_FREQ_BIT] = rotor_probe_freq_error_i; // [RL4]
    fault_raw[PROBE_T1_BIT] = rotor_probe_timing1_error_i; // [RL4]
    fault_raw[PROBE_T2_BIT] = rotor_probe_timing2_error_i; // [RL4]
    fault_raw[BUS_LIMIT_BIT] = bus_current_limit_active_i; // [RL5]
    fault_raw[WINDING_BIT] = winding_measure_error_i; // [RL6]
    fault_raw[BACKEMF_MEAS_BIT] = backemf_measure_error_i; // [RL6]
    fault_raw[RATE_LOCK_BIT] = abnormal_rate_lock_i; // [RL7]
    fault_raw[BACKEMF_LOCK_BIT] = abnormal_backemf_lock_i; // [RL7]
    fault_raw[ABSENT_BIT] = motor_absent_error_i; // [RL7]
    fault_raw[ANY_LOCK_BIT] = any_lock; // [RL7]
    fault_raw[LOCK_CURRENT_BIT] = lock_current_error_i; // [RL8]
    fault_raw[HW_LOCK_BIT] = hw_lock_s; // [RL8]
    fault_raw[SUPPLY_LOW_BIT] = supply_low_s; // [RL9]
    fault_raw[SUPPLY_HIGH_BIT] = supply_high_s; // [RL9]
    fault_raw[SPEED_SAT_BIT] = speed_loop_saturated_i; // [RL10]
    fault_raw[CURRENT_SAT_BIT] = current_loop_saturated_i; // [RL10]
    fault_raw[WATCHDOG_BIT] = watchdog_error_i; // [RL11]
    fault_raw[SELFTEST_EN_BIT] = selftest_enabled_i; // [RL14]
    fault_raw[SELFTEST_RES_BIT] = selftest_result_i; // [RL14]
    fault_raw[APP_RESET_BIT] = app_reset_seen_i; // [RL14]
  end

  // fault writes clear the latched flags; a standing fault sets again at once
  assign fault_clear = wr_i && (addr_i == FAULT_CTRL_OFF) && wdata_i[FAULT_CLEAR_BIT];

  // latched faults hold, live levels follow, summary covers all fault flags
  always_comb begin
    fault_d = (STICKY_MASK & ((fault_q & ~(fault_clear ? STICKY_MASK : REG_RESET)) | fault_raw))
              | (LIVE_MASK & fault_raw); // [RL5] [RL10] [RL14]
    fault_d[SUMMARY_BIT] = |(fault_d & SUMMARY_MASK); // [RL2]
  end

  // fault flags register, read-only to software
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fault_q <= REG_RESET; // [RL1]
    end else if (ce_i) begin
      fault_q <= fault_d; // [RL1]
    end
  end

  // system status snapshots, reserved bits zero
  always_comb begin
    algo_d = REG_RESET;
    algo_d[VOLT_MAG_LSB +: VOLT_MAG_W] = volt_magnitude_i;
    algo_d[DUTY_LSB +: DUTY_W] = duty_command_i;
    algo_d[INIT_DONE_BIT] = init_done_i;
    algo_d[SYS_ENABLE_BIT] = system_enabled_i;
    motor_d = REG_RESET;
    motor_d[MOTOR_R_LSB +: MOTOR_W] = winding_resistance_i;
    motor_d[BEMF_CONST_LSB +: MOTOR_W] = backemf_constant_i;
    motor_d[MOTOR_L_LSB +: MOTOR_W] = winding_inductance_i;
    meas_d = REG_RESET;
    meas_d[MEAS_STAT_LSB +: MEAS_STAT_W] = measure_status_i;
    meas_d[PWM_FREQ_LSB +: PWM_FREQ_W] = measure_pwm_freq_i;
  end

  // system status registers
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      algo_q <= REG_RESET; // [RL12]
      motor_q <= REG_RESET; // [RL12]
      meas_q <= REG_RESET; // [RL12]
    end else if (ce_i) begin
      algo_q <= algo_d;
      motor_q <= motor_d;
      meas_q <= meas_d;
    end
  end

  // interrupt events: new latched fault, watchdog rise, init done, measure done
  always_comb begin
    irq_event = '0;
    irq_event[IRQ_FAULT_BIT] = |(STICKY_MASK & fault_d & ~fault_q);
    irq_event[IRQ_WATCHDOG_BIT] = fault_d[WATCHDOG_BIT] & ~fault_q[WATCHDOG_BIT];
    irq_event[IRQ_INIT_BIT] = algo_d[INIT_DONE_BIT] & ~algo_q[INIT_DONE_BIT];
    irq_event[IRQ_MEAS_BIT] = |(meas_d[MEAS_STAT_LSB +: MEAS_STAT_W] & ~meas_q[MEAS_STAT_LSB +: MEAS_STAT_W]);
  end

  // interrupt register strobes
  assign irq_clear_we = wr_i && (addr_i == IRQ_CLEAR_OFF);
  assign irq_enable_we = wr_i && (addr_i == IRQ_ENABLE_OFF);

  irq_bank #(
    .WIDTH(IRQ_W)
  ) u_irq (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .event_i(irq_event),
    .clear_we_i(irq_clear_we),
    .enable_we_i(irq_enable_we),
    .wdata_i(wdata_i[IRQ_W-1:0]),
    .status_o(irq_status),
    .enable_o(irq_enable),
    .irq_o(irq_o)
  );

  // read decode; write-only, unlisted and unmapped offsets read zero
  always_comb begin
    rdata_d = REG_RESET;
    if (rd_i) begin
      case (addr_i)
        FAULT_FLAGS_OFF: begin
          rdata_d = fault_q; // [RL1]
        end
        ALGO_STATE_OFF: begin
          rdata_d = algo_q; // [RL12]
        end
        MOTOR_VALUES_OFF: begin
          rdata_d = motor_q; // [RL12]
        end
        MEASURE_STATE_OFF: begin
          rdata_d = meas_q; // [RL12]
        end
        IRQ_STATUS_OFF: begin
          rdata_d[IRQ_W-1:0] = irq_status;
        end
        IRQ_ENABLE_OFF: begin
          rdata_d[IRQ_W-1:0] = irq_enable;
        end
        default: begin
          rdata_d = REG_RESET; // [RL13]
        end
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= REG_RESET;
    end else if (ce_i) begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;
endmodule : controller_fault_status_bank

// file: verification/fault_bank_monitor.sv
/*
  checker for the controller fault status bank, bound to its top module.
  assumes it sees only the bank's ports, on the single clock mclk_i.
*/
module fault_bank_monitor
  import fault_status_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [fault_status_pkg::ADDR_W-1:0] addr_i,
  input wire logic [fault_status_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [fault_status_pkg::DATA_W-1:0] rdata_o,
  input wire logic irq_o,
  input wire logic bus_current_limit_active_i
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  // read of the fault register, and whether an address is readable
  logic rd_flt;
  logic rd_map;
  assign rd_flt = ce_i && rd_i && addr_i == FAULT_FLAGS_OFF;
  assign rd_map = addr_i inside {FAULT_FLAGS_OFF, ALGO_STATE_OFF, MOTOR_VALUES_OFF, MEASURE_STATE_OFF,
                                 IRQ_STATUS_OFF, IRQ_ENABLE_OFF};

  // register port and fault register relations
  AST_OUT_OF_RESET: assert property ($rose(rstn_i) |-> rdata_o == '0 && !irq_o)
    else $error("outputs not clear after reset");
  AST_IDLE_ZERO: assert property (ce_i && !rd_i |=> rdata_o == '0)
    else $error("read data not zero outside a read");
  AST_SUMMARY_OR: assert property (rd_flt |=> rdata_o[SUMMARY_BIT] == |(rdata_o & SUMMARY_MASK))
    else $error("summary bit differs from the or of the flags");
  AST_RSVD_ZERO: assert property (rd_flt |=> rdata_o[13:4] == 10'h000)
    else $error("reserved fault bits not zero");
  AST_ANY_LOCK: assert property (rd_flt |=> rdata_o[ANY_LOCK_BIT] == |{rdata_o[23:21], rdata_o[19:18]})
    else $error("any lock bit differs from the lock flags");
  AST_BUS_LIMIT_LIVE: assert property (rd_flt && $stable(bus_current_limit_active_i) |=>
    rdata_o[BUS_LIMIT_BIT] == $past(bus_current_limit_active_i))
    else $error("bus limit bit does not follow its input");
  AST_UNMAPPED_ZERO: assert property (ce_i && rd_i && !rd_map |=> rdata_o == '0)
    else $error("unmapped read not zero");
  AST_ALGO_LOW_ZERO: assert property (ce_i && rd_i && addr_i == ALGO_STATE_OFF |=> rdata_o[1:0] == 2'h0)
    else $error("algorithm state low bits not zero");
  AST_MOTOR_LOW_ZERO: assert property (ce_i && rd_i && addr_i == MOTOR_VALUES_OFF |=> rdata_o[7:0] == 8'h00)
    else $error("motor values low byte not zero");
  AST_IRQ_MASKED: assert property (ce_i && wr_i && addr_i == IRQ_ENABLE_OFF && wdata_i[IRQ_W-1:0] == '0 |=> !irq_o)
    else $error("interrupt high with all enables off");

  // main scenarios
  COV_SUMMARY: cover property (rd_flt ##1 rdata_o[SUMMARY_BIT]);
  COV_IRQ: cover property ($rose(irq_o));
  COV_UNMAPPED: cover property (rd_i && !rd_map);
endmodule : fault_bank_monitor

bind controller_fault_status_bank fault_bank_monitor mon_u (.mclk_i, .rstn_i, .ce_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .irq_o, .bus_current_limit_active_i);

// file: verification/test_controller_fault_status_bank.sv
/*
  self-checking bench for the controller fault status bank.
  assumes the bench drives every port itself; clock enable held high except during the final clock enable test.
*/
module test_controller_fault_status_bank;
  timeunit 1ns;
  timeprecision 1ns;
  import fault_status_pkg::*;

  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic irq;
  logic [19:0] fv = '0;
  logic [15:0] volt = '0;
  logic [11:0] duty = '0;
  logic init = 1'b0;
  logic sen = 1'b0;
  logic [7:0] res = '0;
  logic [7:0] bemf = '0;
  logic [7:0] ind = '0;
  logic [3:0] mst = '0;
  logic [3:0] mpf = '0;
  int n_fail = 0;
  int tests_run = 0;
  int pos[20] = '{30, 29, 28, 27, 26, 25, 24, 23, 22, 21, 19, 15, 14, 3, 2, 1, 0, 18, 17, 16};
  logic [7:0] ra[9] = '{8'he2, 8'he4, 8'he6, 8'he8, 8'he3, 8'hf0, 8'hf1, 8'hf2, 8'hf3};

  controller_fault_status_bank dut_u (
    .mclk_i(mclk), .rstn_i(rstn), .ce_i(ce), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .irq_o(irq), .engine_overtemp_flag_i(fv[0]), .rotor_probe_freq_error_i(fv[1]),
    .rotor_probe_timing1_error_i(fv[2]), .rotor_probe_timing2_error_i(fv[3]),
    .bus_current_limit_active_i(fv[4]), .winding_measure_error_i(fv[5]), .backemf_measure_error_i(fv[6]),
    .abnormal_rate_lock_i(fv[7]), .abnormal_backemf_lock_i(fv[8]), .motor_absent_error_i(fv[9]),
    .lock_current_error_i(fv[10]), .speed_loop_saturated_i(fv[11]), .current_loop_saturated_i(fv[12]),
    .watchdog_error_i(fv[13]), .selftest_enabled_i(fv[14]), .selftest_result_i(fv[15]),
    .app_reset_seen_i(fv[16]), .hardware_lock_current_error_i(fv[17]), .motor_supply_low_error_i(fv[18]),
    .motor_supply_high_error_i(fv[19]), .volt_magnitude_i(volt), .duty_command_i(duty), .init_done_i(init),
    .system_enabled_i(sen), .winding_resistance_i(res), .backemf_constant_i(bemf),
    .winding_inductance_i(ind), .measure_status_i(mst), .measure_pwm_freq_i(mpf)
  );

  // 10 MHz clock
  always #50 mclk = ~mclk;

  // compare and count
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // one-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  // one-cycle read strobe, data checked in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 check($sformatf("reg %h", a), rdata, e);
  endtask : rd_chk

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  // main sequence
  initial begin
    logic [31:0] e;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    foreach (ra[k]) rd_chk(ra[k], 32'h0);
    // unlisted offset 0xe3 is only read, never written
    for (int k = 0; k < 7; k++) begin
      if (ra[k] != 8'he3) begin
        wr_reg(ra[k], 32'hffff_ffff);
      end
    end
    for (int k = 0; k < 7; k++) rd_chk(ra[k], 32'h0);
    $display("reset and read-only test done");
    for (int i = 0; i < 20; i++) begin
      e = 32'h1 << pos[i];
      if (SUMMARY_MASK[pos[i]]) e[SUMMARY_BIT] = 1'b1;
      if (pos[i] inside {23, 22, 21, 19, 18}) e[ANY_LOCK_BIT] = 1'b1;
      @(posedge mclk);
      fv[i] <= 1'b1;
      repeat (4) @(posedge mclk);
      rd_chk(FAULT_FLAGS_OFF, e);
      @(posedge mclk);
      fv[i] <= 1'b0;
      repeat (4) @(posedge mclk);
      rd_chk(FAULT_FLAGS_OFF, STICKY_MASK[pos[i]] ? e : 32'h0);
      wr_reg(FAULT_CTRL_OFF, 32'h1);
      rd_chk(FAULT_FLAGS_OFF, 32'h0);
    end
    $display("fault flag test done");
    wr_reg(IRQ_CLEAR_OFF, 32'hf);
    wr_reg(IRQ_ENABLE_OFF, 32'hf);
    rd_chk(IRQ_ENABLE_OFF, 32'hf);
    rd_chk(IRQ_STATUS_OFF, 32'h0);
    @(posedge mclk);
    fv[13] <= 1'b1;
    repeat (4) @(posedge mclk);
    check("irq", {31'h0, irq}, 32'h1);
    rd_chk(IRQ_STATUS_OFF, 32'h3);
    // clearing while the watchdog is still high must leave it set
    wr_reg(FAULT_CTRL_OFF, 32'h1);
    rd_chk(FAULT_FLAGS_OFF, 32'h8000_0008);
    wr_reg(IRQ_ENABLE_OFF, 32'h0);
    #1 check("irq", {31'h0, irq}, 32'h0);
    @(posedge mclk);
    fv[13] <= 1'b0;
    wr_reg(FAULT_CTRL_OFF, 32'h1);
    wr_reg(IRQ_CLEAR_OFF, 32'hf);
    wr_reg(IRQ_ENABLE_OFF, 32'hf);
    #1 check("irq", {31'h0, irq}, 32'h0);
    rd_chk(IRQ_STATUS_OFF, 32'h0);
    $display("interrupt test done");
    @(posedge mclk);
    volt <= 16'h1234;
    duty <= 12'habc;
    init <= 1'b1;
    sen <= 1'b1;
    res <= 8'h5a;
    bemf <= 8'ha5;
    ind <= 8'h3c;
    mst <= 4'h9;
    mpf <= 4'h6;
    repeat (3) @(posedge mclk);
    rd_chk(ALGO_STATE_OFF, 32'h1234_abcc);
    rd_chk(MOTOR_VALUES_OFF, 32'h5aa5_3c00);
    rd_chk(MEASURE_STATE_OFF, 32'h9600_0000);
    rd_chk(IRQ_STATUS_OFF, 32'hc);
    check("irq", {31'h0, irq}, 32'h1);
    rd_chk(FAULT_FLAGS_OFF, 32'h0);
    $display("system status test done");
    // a fault seen only while the clock enable is low must not latch
    @(posedge mclk);
    ce <= 1'b0;
    fv[13] <= 1'b1;
    repeat (4) @(posedge mclk);
    fv[13] <= 1'b0;
    ce <= 1'b1;
    rd_chk(FAULT_FLAGS_OFF, 32'h0);
    rd_chk(IRQ_STATUS_OFF, 32'hc);
    $display("clock enable test done");
    summarize();
  end
endmodule : test_controller_fault_status_bank
